/* inc/misx_pkg.sv */
`default_nettype none

package misx_pkg;
    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int PC_W = 16;
    localparam int K_W = 13;
    localparam int PG_W = PC_W - K_W;
    localparam int FA_W = 9;
    localparam int STK_D = 8;
    localparam int SP_W = 3;
    localparam int FREG_N = 512;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // ----------------------------------------
    // opcode fields
    // ----------------------------------------
    localparam logic [15:0] OPC_NOP = 16'h0000;
    localparam logic [15:0] OPC_RET = 16'h0040;
    localparam logic [15:0] OPC_KICK = 16'h1E04;
    localparam logic [7:0] OPH_ORL = 8'h1A;
    localparam logic [7:0] OPH_MOVL = 8'h19;
    localparam logic [2:0] OPB_CALL = 3'h4;
    localparam logic [2:0] OPB_JMP = 3'h5;
    localparam logic [3:0] FOP_MOVWF = 4'h0;
    localparam logic [3:0] FOP_DEC = 4'h3;
    localparam logic [3:0] FOP_ORF = 4'h4;
    localparam logic [3:0] FOP_MOVF = 4'h8;
    localparam logic [3:0] FOP_INV = 4'h9;
    localparam logic [3:0] FOP_INC = 4'hA;
    localparam logic [3:0] FOP_DECSZ = 4'hB;
    localparam logic [3:0] FOP_INCSZ = 4'hF;

    typedef enum logic [3:0] {
        OP_NOP, OP_KICK, OP_INV, OP_DEC, OP_DECSZ, OP_INC, OP_INCSZ, OP_ORL,
        OP_ORF, OP_CALL, OP_JMP, OP_MOVF, OP_MOVL, OP_MOVWF, OP_RET
    } misx_op_t;

    // gray along run -> flush(advance) -> flush(hold)
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FLUSH_ADV = 2'b01,
        ST_FLUSH_HOLD = 2'b11
    } misx_phase_t;

    typedef struct packed {
        misx_op_t op;
        logic [FA_W-1:0] addr;
        logic d;
        logic [7:0] k8;
        logic [K_W-1:0] k13;
    } misx_dec_t;

    typedef struct packed {
        misx_phase_t phase;
        logic [PC_W-1:0] pc;
        logic [7:0] acc;
        logic zf;
        logic tof;
        logic pdf;
        logic [7:0] wdt;
        logic [SP_W-1:0] sp;
        logic [STK_D-1:0][PC_W-1:0] stk;
        logic wr_en;
        logic [FA_W-1:0] wr_addr;
        logic [7:0] wr_data;
    } misx_state_t;

    function automatic misx_dec_t decode(input logic [15:0] ins);
        misx_dec_t r;
        r.addr = {ins[15:14], ins[6:0]};
        r.d = ins[7];
        r.k8 = ins[7:0];
        r.k13 = {ins[15:14], ins[10:0]};
        r.op = OP_NOP;
        if (ins == OPC_KICK) begin
            r.op = OP_KICK;
        end else if (ins == OPC_RET) begin
            r.op = OP_RET;
        end else if (ins[15:8] == OPH_ORL) begin
            r.op = OP_ORL;
        end else if (ins[15:8] == OPH_MOVL) begin
            r.op = OP_MOVL;
        end else if (ins[13:11] == OPB_CALL) begin
            r.op = OP_CALL;
        end else if (ins[13:11] == OPB_JMP) begin
            r.op = OP_JMP;
        end else if (ins[13:12] == 2'b00) begin
            case (ins[11:8])
                FOP_MOVWF: r.op = ins[7] ? OP_MOVWF : OP_NOP;
                FOP_DEC: r.op = OP_DEC;
                FOP_ORF: r.op = OP_ORF;
                FOP_MOVF: r.op = OP_MOVF;
                FOP_INV: r.op = OP_INV;
                FOP_INC: r.op = OP_INC;
                FOP_DECSZ: r.op = OP_DECSZ;
                FOP_INCSZ: r.op = OP_INCSZ;
                default: r.op = OP_NOP;
            endcase
        end
        return r;
    endfunction
endpackage

`default_nettype wire

/* rtl/misx_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - watchdog_kick zeroes watchdog counter in one cycle, sets expiry and sleep flags
// - file operand addresses 0..1FF; d=0 writes accumulator, d=1 writes file
// - invert_file writes complement to destination, one cycle, updates null flag
// - file_decrement writes value minus one, one cycle, updates null flag
// - file_decrement_skip stores result, no flags; zero result turns next op into nop
// - file_increment writes value plus one, wraps FF to 00, updates null flag
// - file_increment_skip stores result, no flags; zero result discards next op
// - or_literal ORs accumulator with immediate into accumulator, updates null flag
// - or_file ORs accumulator with file into destination, updates null flag
// - long_call pushes pc+1, loads 13-bit target plus page bits, two cycles
// - long_jump loads 13-bit target plus page bits, two cycles, stack untouched
// - file_move copies file to destination and updates null flag
// - file_to_accumulator copies addressed file register into accumulator
// - literal_to_accumulator loads immediate into accumulator, flags unchanged
// - accumulator_to_file writes accumulator to file, flags unchanged
// - subroutine_exit pops stack into pc, two cycles, flags unchanged
module misx_core (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [15:0] instr_i,
    input wire logic [misx_pkg::PG_W-1:0] page_latch_high_i,
    output logic [misx_pkg::PC_W-1:0] pc_o,
    output logic [7:0] acc_o,
    output logic null_result_flag_o,
    output logic watchdog_expiry_flag_o,
    output logic sleep_flag_o,
    output logic [7:0] wdt_count_o,
    output logic [misx_pkg::SP_W-1:0] stack_ptr_o,
    output logic file_we_o,
    output logic [misx_pkg::FA_W-1:0] file_addr_o,
    output logic [7:0] file_data_o
);
    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    misx_pkg::misx_state_t st_r;
    misx_pkg::misx_state_t st_nxt;
    misx_pkg::misx_dec_t dc;
    logic [7:0] fmem [misx_pkg::FREG_N];
    logic [7:0] rdata;
    logic [7:0] res;
    logic wr_res;
    logic upd_z;
    logic run;
    logic [misx_pkg::PC_W-1:0] tgt;
    logic [misx_pkg::PC_W-1:0] head;

    localparam misx_pkg::misx_state_t ST_RST = '{
        phase: misx_pkg::ST_RUN,
        pc: misx_pkg::PC_RST,
        acc: misx_pkg::BYTE_RST,
        zf: 1'b0,
        tof: 1'b0,
        pdf: 1'b0,
        wdt: misx_pkg::BYTE_RST,
        sp: '0,
        stk: '0,
        wr_en: 1'b0,
        wr_addr: '0,
        wr_data: misx_pkg::BYTE_RST
    };

    assign dc = misx_pkg::decode(instr_i);
    assign rdata = fmem[dc.addr];
    assign run = (st_r.phase == misx_pkg::ST_RUN);
    assign tgt = {page_latch_high_i, dc.k13};
    assign head = st_r.stk[st_r.sp - 3'd1];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        res = misx_pkg::BYTE_RST;
        wr_res = 1'b0;
        upd_z = 1'b0;
        st_nxt.wr_en = 1'b0;
        st_nxt.wdt = st_r.wdt + 8'h01;
        case (st_r.phase)
            misx_pkg::ST_RUN: begin
                st_nxt.pc = st_r.pc + 16'h0001;
                case (dc.op)
                    misx_pkg::OP_KICK: begin
                        st_nxt.wdt = misx_pkg::BYTE_RST;
                        st_nxt.tof = 1'b1;
                        st_nxt.pdf = 1'b1;
                    end
                    misx_pkg::OP_INV: begin
                        res = ~rdata;
                        wr_res = 1'b1;
                        upd_z = 1'b1;
                    end
                    misx_pkg::OP_DEC: begin
                        res = rdata - 8'h01;
                        wr_res = 1'b1;
                        upd_z = 1'b1;
                    end
                    misx_pkg::OP_DECSZ: begin
                        res = rdata - 8'h01;
                        wr_res = 1'b1;
                        if (res == 8'h00) begin
                            st_nxt.phase = misx_pkg::ST_FLUSH_ADV;
                        end
                    end
                    misx_pkg::OP_INC: begin
                        res = rdata + 8'h01;
                        wr_res = 1'b1;
                        upd_z = 1'b1;
                    end
                    misx_pkg::OP_INCSZ: begin
                        res = rdata + 8'h01;
                        wr_res = 1'b1;
                        if (res == 8'h00) begin
                            st_nxt.phase = misx_pkg::ST_FLUSH_ADV;
                        end
                    end
                    misx_pkg::OP_ORL: begin
                        st_nxt.acc = st_r.acc | dc.k8;
                        st_nxt.zf = ((st_r.acc | dc.k8) == 8'h00);
                    end
                    misx_pkg::OP_ORF: begin
                        res = st_r.acc | rdata;
                        wr_res = 1'b1;
                        upd_z = 1'b1;
                    end
                    misx_pkg::OP_MOVF: begin
                        res = rdata;
                        wr_res = 1'b1;
                        upd_z = 1'b1;
                    end
                    misx_pkg::OP_MOVL: begin
                        st_nxt.acc = dc.k8;
                    end
                    misx_pkg::OP_MOVWF: begin
                        res = st_r.acc;
                        wr_res = 1'b1;
                    end
                    misx_pkg::OP_CALL: begin
                        st_nxt.stk[st_r.sp] = st_r.pc + 16'h0001;
                        st_nxt.sp = st_r.sp + 3'd1;
                        st_nxt.pc = tgt;
                        st_nxt.phase = misx_pkg::ST_FLUSH_HOLD;
                    end
                    misx_pkg::OP_JMP: begin
                        st_nxt.pc = tgt;
                        st_nxt.phase = misx_pkg::ST_FLUSH_HOLD;
                    end
                    misx_pkg::OP_RET: begin
                        st_nxt.pc = head;
                        st_nxt.sp = st_r.sp - 3'd1;
                        st_nxt.phase = misx_pkg::ST_FLUSH_HOLD;
                    end
                    default: begin
                        // all-zero and unlisted opcodes only advance pc
                    end
                endcase
            end
            misx_pkg::ST_FLUSH_ADV: begin
                // skipped opcode is dropped, pc steps past it
                st_nxt.pc = st_r.pc + 16'h0001;
                st_nxt.phase = misx_pkg::ST_RUN;
            end
            misx_pkg::ST_FLUSH_HOLD: begin
                // pc already holds the branch target; its opcode arrives now but runs next
                st_nxt.phase = misx_pkg::ST_RUN;
            end
            default: begin
                st_nxt.phase = misx_pkg::ST_RUN;
            end
        endcase
        if (wr_res) begin
            if (dc.d || dc.op == misx_pkg::OP_MOVWF) begin
                st_nxt.wr_en = 1'b1;
                st_nxt.wr_addr = dc.addr;
                st_nxt.wr_data = res;
            end else begin
                st_nxt.acc = res;
            end
        end
        if (upd_z) begin
            st_nxt.zf = (res == 8'h00);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // file contents are data, so no reset; writes still wait for reset release
    always_ff @(posedge mclk_i) begin
        if (rstn_i && st_nxt.wr_en) begin
            fmem[st_nxt.wr_addr] <= st_nxt.wr_data;
        end
    end

    assign pc_o = st_r.pc;
    assign acc_o = st_r.acc;
    assign null_result_flag_o = st_r.zf;
    assign watchdog_expiry_flag_o = st_r.tof;
    assign sleep_flag_o = st_r.pdf;
    assign wdt_count_o = st_r.wdt;
    assign stack_ptr_o = st_r.sp;
    assign file_we_o = st_r.wr_en;
    assign file_addr_o = st_r.wr_addr;
    assign file_data_o = st_r.wr_data;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_kick;
        run && dc.op == misx_pkg::OP_KICK |=> st_r.wdt == 8'h00 && st_r.tof && st_r.pdf;
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not clear watchdog");

    property p_inv;
        run && dc.op == misx_pkg::OP_INV
            |=> ($past(dc.d) ? st_r.wr_data : st_r.acc) == ~$past(rdata) && st_r.zf == ($past(rdata) == 8'hFF);
    endproperty
    a_inv: assert property (p_inv) else $error("complement wrong");

    property p_dec;
        run && dc.op == misx_pkg::OP_DEC
            |=> ($past(dc.d) ? st_r.wr_data : st_r.acc) == $past(rdata) - 8'h01
            && st_r.wr_en == $past(dc.d) && st_r.zf == ($past(rdata) == 8'h01);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");

    property p_dsz;
        run && dc.op == misx_pkg::OP_DECSZ && rdata == 8'h01
            |=> st_r.phase == misx_pkg::ST_FLUSH_ADV && $stable(st_r.zf) ##1 st_r.phase == misx_pkg::ST_RUN;
    endproperty
    a_dsz: assert property (p_dsz) else $error("decrement skip wrong");

    property p_inc;
        run && dc.op == misx_pkg::OP_INC |=> st_r.zf == ($past(rdata) == 8'hFF);
    endproperty
    a_inc: assert property (p_inc) else $error("increment flag wrong");

    property p_isz;
        run && dc.op == misx_pkg::OP_INCSZ
            |=> $stable(st_r.zf) && (st_r.phase == misx_pkg::ST_FLUSH_ADV) == ($past(rdata) == 8'hFF);
    endproperty
    a_isz: assert property (p_isz) else $error("increment skip wrong");

    property p_orl;
        run && dc.op == misx_pkg::OP_ORL |=> st_r.acc == ($past(st_r.acc) | $past(dc.k8));
    endproperty
    a_orl: assert property (p_orl) else $error("or literal wrong");

    property p_orl_z;
        run && dc.op == misx_pkg::OP_ORL |=> st_r.zf == (st_r.acc == 8'h00);
    endproperty
    a_orl_z: assert property (p_orl_z) else $error("null flag after or literal wrong");

    property p_orf;
        run && dc.op == misx_pkg::OP_ORF
            |=> ($past(dc.d) ? st_r.wr_data : st_r.acc) == ($past(st_r.acc) | $past(rdata))
            && st_r.zf == (($past(st_r.acc) | $past(rdata)) == 8'h00);
    endproperty
    a_orf: assert property (p_orf) else $error("or file wrong");

    property p_movf;
        run && dc.op == misx_pkg::OP_MOVF
            |=> ($past(dc.d) ? st_r.wr_data : st_r.acc) == $past(rdata) && st_r.zf == ($past(rdata) == 8'h00);
    endproperty
    a_movf: assert property (p_movf) else $error("move file wrong");

    property p_dest_file;
        run && dc.d && dc.op inside {misx_pkg::OP_INV, misx_pkg::OP_DEC, misx_pkg::OP_DECSZ, misx_pkg::OP_INC,
            misx_pkg::OP_INCSZ, misx_pkg::OP_ORF, misx_pkg::OP_MOVF}
            |=> st_r.wr_en && st_r.wr_addr == $past(dc.addr) && $stable(st_r.acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

    property p_dest_acc;
        run && !dc.d && dc.op inside {misx_pkg::OP_INV, misx_pkg::OP_DEC, misx_pkg::OP_DECSZ, misx_pkg::OP_INC,
            misx_pkg::OP_INCSZ, misx_pkg::OP_ORF, misx_pkg::OP_MOVF}
            |=> !st_r.wr_en;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrote file");

    property p_wdt;
        !(run && dc.op == misx_pkg::OP_KICK) |=> st_r.wdt == $past(st_r.wdt) + 8'h01;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog count wrong");

    property p_call;
        run && dc.op == misx_pkg::OP_CALL |=> st_r.sp == $past(st_r.sp) + 3'd1 && st_r.pc == $past(tgt)
            ##1 st_r.pc == $past(st_r.pc) && run;
    endproperty
    a_call: assert property (p_call) else $error("call wrong");

    property p_jmp;
        run && dc.op == misx_pkg::OP_JMP |=> $stable(st_r.sp) && st_r.pc == $past(tgt) && !run;
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump wrong");

    property p_ret;
        run && dc.op == misx_pkg::OP_RET |=> st_r.pc == $past(head) && $stable(st_r.zf) && !run;
    endproperty
    a_ret: assert property (p_ret) else $error("return wrong");

    property p_movl;
        run && dc.op == misx_pkg::OP_MOVL |=> st_r.acc == $past(dc.k8) && $stable(st_r.zf);
    endproperty
    a_movl: assert property (p_movl) else $error("literal load wrong");

    property p_movwf;
        run && dc.op == misx_pkg::OP_MOVWF
            |=> st_r.wr_en && st_r.wr_data == $past(st_r.acc) && st_r.wr_addr == $past(dc.addr) && $stable(st_r.zf);
    endproperty
    a_movwf: assert property (p_movwf) else $error("store accumulator wrong");

    property p_nop;
        run && instr_i == misx_pkg::OPC_NOP
            |=> $stable(st_r.acc) && $stable(st_r.sp) && $stable(st_r.zf) && !st_r.wr_en && run;
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");

    c_skip: cover property (run && dc.op == misx_pkg::OP_INCSZ && rdata == 8'hFF);
    c_call_ret: cover property (run && dc.op == misx_pkg::OP_CALL ##[2:20] run && dc.op == misx_pkg::OP_RET);
    c_kick: cover property (run && dc.op == misx_pkg::OP_KICK);
    c_jump: cover property (run && dc.op == misx_pkg::OP_JMP);
    c_dec_skip: cover property (run && dc.op == misx_pkg::OP_DECSZ && rdata == 8'h01);
endmodule

`default_nettype wire

/* tb/misx_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// program memory model
// ----------------------------------------
module misx_prog_mem (
    input wire logic [15:0] addr_i,
    output logic [15:0] data_o
);
    logic [15:0] mem [0:255];

    // upper address bits fold onto the array, so test targets must stay apart in the low byte
    assign data_o = mem[addr_i[7:0]];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
    end
endmodule

`default_nettype wire

/* tb/misx_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// testbench
// ----------------------------------------
module misx_core_tb;
    logic mclk, rstn, zf, tof, pdf, we;
    logic [2:0] page, sp;
    logic [15:0] instr, pc;
    logic [7:0] acc, wdt, wd;
    logic [8:0] wa;
    logic [15:0] prog [0:20];
    int err_count, n_compared;

    misx_core misx_core_inst (.mclk_i(mclk), .rstn_i(rstn), .instr_i(instr), .page_latch_high_i(page),
        .pc_o(pc), .acc_o(acc), .null_result_flag_o(zf), .watchdog_expiry_flag_o(tof),
        .sleep_flag_o(pdf), .wdt_count_o(wdt), .stack_ptr_o(sp), .file_we_o(we),
        .file_addr_o(wa), .file_data_o(wd));
    misx_prog_mem misx_prog_mem_inst (.addr_i(pc), .data_o(instr));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [15:0] fop(input logic [3:0] op, input logic d, input logic [8:0] a);
        return {a[8:7], 2'b00, op, d, a[6:0]};
    endfunction

    function automatic logic [15:0] br(input logic [2:0] b, input logic [12:0] k);
        return {k[12:11], b, k[10:0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one executing edge, outputs compared at the following falling edge
    task automatic step(input logic [15:0] epc, input logic [7:0] eacc, input logic ez, input logic ewe,
        input logic [8:0] ewa, input logic [7:0] ewd);
        @(negedge mclk);
        check("pc", pc, epc);
        check("acc", {8'h00, acc}, {8'h00, eacc});
        check("null flag", {15'h0000, zf}, {15'h0000, ez});
        check("write strobe", {15'h0000, we}, {15'h0000, ewe});
        if (ewe) begin
            check("write addr", {7'h00, wa}, {7'h00, ewa});
            check("write data", {8'h00, wd}, {8'h00, ewd});
        end
    endtask

    task automatic rst_ck();
        check("pc", pc, 16'h0000);
        check("acc", {8'h00, acc}, 16'h0000);
        check("flags", {12'h000, zf, tof, pdf, we}, 16'h0000);
        check("stack ptr", {13'h0000, sp}, 16'h0000);
        check("wdt", {8'h00, wdt}, 16'h0000);
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // a hang is cut short here; the main sequence needs well under this many cycles
    initial begin
        repeat (2000) @(posedge mclk);
        err_count++;
        $display("wrong value run length expected end seen timeout");
        complete_run();
    end

    initial begin
        rstn = 1'b0;
        page = 3'h0;
        err_count = 0;
        n_compared = 0;
        repeat (5) @(negedge mclk);
        rst_ck();
        prog = '{16'h195A, fop(misx_pkg::FOP_MOVWF, 1'b1, 9'h105), fop(misx_pkg::FOP_INV, 1'b1, 9'h105),
            fop(misx_pkg::FOP_MOVF, 1'b0, 9'h105), 16'h1900, 16'h1A00, 16'h19FF,
            fop(misx_pkg::FOP_MOVWF, 1'b1, 9'h010), fop(misx_pkg::FOP_INC, 1'b1, 9'h010),
            fop(misx_pkg::FOP_DEC, 1'b0, 9'h010), fop(misx_pkg::FOP_ORF, 1'b1, 9'h010),
            fop(misx_pkg::FOP_INCSZ, 1'b1, 9'h010), 16'h1977, 16'h1901,
            fop(misx_pkg::FOP_MOVWF, 1'b1, 9'h011), fop(misx_pkg::FOP_DECSZ, 1'b1, 9'h011), 16'h1977,
            misx_pkg::OPC_KICK, misx_pkg::OPC_NOP, br(misx_pkg::OPB_CALL, 13'h0030),
            br(misx_pkg::OPB_JMP, 13'h0040)};
        for (int i = 0; i < 21; i++) begin
            misx_prog_mem_inst.mem[i] = prog[i];
        end
        misx_prog_mem_inst.mem[8'h30] = 16'h193C;
        misx_prog_mem_inst.mem[8'h31] = misx_pkg::OPC_RET;
        misx_prog_mem_inst.mem[8'h40] = fop(misx_pkg::FOP_MOVF, 1'b1, 9'h011);
        rstn = 1'b1;
        step(16'h0001, 8'h5A, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h0002, 8'h5A, 1'b0, 1'b1, 9'h105, 8'h5A);
        step(16'h0003, 8'h5A, 1'b0, 1'b1, 9'h105, 8'hA5);
        step(16'h0004, 8'hA5, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h0005, 8'h00, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h0006, 8'h00, 1'b1, 1'b0, 9'h000, 8'h00);
        step(16'h0007, 8'hFF, 1'b1, 1'b0, 9'h000, 8'h00);
        step(16'h0008, 8'hFF, 1'b1, 1'b1, 9'h010, 8'hFF);
        step(16'h0009, 8'hFF, 1'b1, 1'b1, 9'h010, 8'h00);
        step(16'h000A, 8'hFF, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h000B, 8'hFF, 1'b0, 1'b1, 9'h010, 8'hFF);
        $display("file operation test done");
        step(16'h000C, 8'hFF, 1'b0, 1'b1, 9'h010, 8'h00);
        step(16'h000D, 8'hFF, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h000E, 8'h01, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h000F, 8'h01, 1'b0, 1'b1, 9'h011, 8'h01);
        step(16'h0010, 8'h01, 1'b0, 1'b1, 9'h011, 8'h00);
        step(16'h0011, 8'h01, 1'b0, 1'b0, 9'h000, 8'h00);
        $display("skip test done");
        step(16'h0012, 8'h01, 1'b0, 1'b0, 9'h000, 8'h00);
        check("wdt", {8'h00, wdt}, 16'h0000);
        check("status", {14'h0000, tof, pdf}, 16'h0003);
        step(16'h0013, 8'h01, 1'b0, 1'b0, 9'h000, 8'h00);
        check("stack ptr", {13'h0000, sp}, 16'h0000);
        check("wdt", {8'h00, wdt}, 16'h0001);
        check("status", {14'h0000, tof, pdf}, 16'h0003);
        page = 3'h1;
        step(16'h2030, 8'h01, 1'b0, 1'b0, 9'h000, 8'h00);
        check("stack ptr", {13'h0000, sp}, 16'h0001);
        step(16'h2030, 8'h01, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h2031, 8'h3C, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h0014, 8'h3C, 1'b0, 1'b0, 9'h000, 8'h00);
        check("stack ptr", {13'h0000, sp}, 16'h0000);
        page = 3'h0;
        step(16'h0014, 8'h3C, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h0040, 8'h3C, 1'b0, 1'b0, 9'h000, 8'h00);
        check("stack ptr", {13'h0000, sp}, 16'h0000);
        step(16'h0040, 8'h3C, 1'b0, 1'b0, 9'h000, 8'h00);
        step(16'h0041, 8'h3C, 1'b1, 1'b1, 9'h011, 8'h00);
        $display("branch test done");
        rstn = 1'b0;
        @(negedge mclk);
        rst_ck();
        $display("reset test done");
        complete_run();
    end
endmodule

`default_nettype wire
